// ### sbm_sdram_core.sv
// Function
// - Four banks, 16-bit word per clock.
// - 13 row, 9 column, 2 bank bits.
// - Read byte mask acts two cycles later.
// - High read mask floats byte, low drives.
// - Write mask applies in its data cycle.
// - Low mask stores byte, high keeps old.
// - Upper mask high byte, lower low byte.
// - Refreshes before or after mode set accepted.
// - Self-refresh covers selected portion, four periods.
// - Mode set is all strobes low, bank zero.
module sbm_sdram_core
    import sbm_pkg::*;
#(
    parameter int ROW_KEEP = 4,
    parameter int COL_KEEP = 4
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CKE,
    input wire logic CS_N,
    input wire logic RAS_N,
    input wire logic CAS_N,
    input wire logic WE_N,
    input wire logic [SBM_ROW_W-1:0] ADDR,
    input wire logic BANK_SELECT_LOW,
    input wire logic BANK_SELECT_HIGH,
    input wire logic UPPER_BYTE_MASK,
    input wire logic LOWER_BYTE_MASK,
    input wire logic [SBM_DATA_W-1:0] DQ_IN,
    output logic [SBM_DATA_W-1:0] DQ_OUT,
    output logic DQ_OE_HIGH,
    output logic DQ_OE_LOW,
    output logic INIT_DONE,
    output logic SELF_REFRESH_ACTIVE,
    output logic [SBM_BANK_W+SBM_ROW_W-1:0] SELF_REFRESH_ROW
);

    // ------------------------------------------------------------
    // Storage and decode helpers
    // ------------------------------------------------------------
    // The full array is far too large for flip-flops, so only the low row and
    // column bits index storage; higher addresses alias onto it.
    localparam int IDX_W = SBM_BANK_W + ROW_KEEP + COL_KEEP;
    localparam int DEPTH = 1 << IDX_W;

    logic [7:0] mem_hi_reg [DEPTH];
    logic [7:0] mem_lo_reg [DEPTH];

    function automatic logic [IDX_W-1:0] store_idx(input logic [1:0] b,
                                                   input logic [SBM_ROW_W-1:0] r,
                                                   input logic [SBM_COL_W-1:0] c);
        store_idx = {b, r[ROW_KEEP-1:0], c[COL_KEEP-1:0]};
    endfunction

    // Burst order wraps inside a block of the burst length.
    function automatic logic [SBM_COL_W-1:0] burst_col(input logic [SBM_COL_W-1:0] start,
                                                       input logic [2:0] cnt,
                                                       input logic [2:0] len_mask,
                                                       input logic interleave);
        logic [2:0] low;
        low = interleave ? (start[2:0] ^ cnt) : (start[2:0] + cnt);
        burst_col = {start[SBM_COL_W-1:3], (start[2:0] & ~len_mask) | (low & len_mask)};
    endfunction

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic [1:0] bank_in;
    sbm_cmd_e cmd;
    logic cmd_valid;

    assign bank_in = {BANK_SELECT_HIGH, BANK_SELECT_LOW};
    assign cmd = sbm_cmd_e'({RAS_N, CAS_N, WE_N});
    assign cmd_valid = CKE && !CS_N;

    sbm_state_e state_reg;
    logic [12:0] mode_reg;
    logic [4:0] ext_mode_reg;
    logic [SBM_BANKS-1:0] open_reg;
    logic [SBM_ROW_W-1:0] row_reg [SBM_BANKS];
    logic [1:0] bank_reg;
    logic [SBM_COL_W-1:0] col_reg;
    logic [2:0] cnt_reg;

    logic [2:0] len_mask;
    logic [2:0] cl;
    logic all_idle;
    logic burst_last;

    always_comb begin
        unique case (mode_reg[SBM_MR_BL_LSB +: 3])
            3'h1: len_mask = 3'h1;
            3'h2: len_mask = 3'h3;
            3'h3: len_mask = 3'h7;
            default: len_mask = 3'h0;
        endcase
    end

    assign cl = mode_reg[SBM_MR_CL_LSB +: 3];
    assign all_idle = (open_reg == '0) && (state_reg == SBM_ST_IDLE);
    assign burst_last = (cnt_reg == len_mask) ||
                        (state_reg == SBM_ST_WRITE && mode_reg[SBM_MR_WB_BIT]);

    // ------------------------------------------------------------
    // Bank rows and mode registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            open_reg <= '0;
            for (int i = 0; i < SBM_BANKS; i++) begin
                row_reg[i] <= '0;
            end
        end else if (cmd_valid && cmd == SBM_CMD_ACTIVATE) begin
            open_reg[bank_in] <= 1'b1;
            row_reg[bank_in] <= ADDR;
        end else if (cmd_valid && cmd == SBM_CMD_PRECHARGE) begin
            if (ADDR[SBM_PRECHARGE_ALL_BIT]) begin
                open_reg <= '0;
            end else begin
                open_reg[bank_in] <= 1'b0;
            end
        end
    end

    // A mode set while a bank is open is ignored; the contents are undefined
    // only in the sense that software must not lean on the reset value.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            mode_reg <= SBM_MR_RESET;
            ext_mode_reg <= SBM_EMR_RESET;
        end else if (cmd_valid && cmd == SBM_CMD_MODE_SET && all_idle) begin
            if (bank_in == SBM_BA_MODE) begin
                mode_reg <= ADDR;
            end else if (bank_in == SBM_BA_EXT_MODE) begin
                ext_mode_reg <= ADDR[4:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Initialisation progress
    // ------------------------------------------------------------
    logic pre_all_seen_reg;
    logic mode_seen_reg;
    logic [1:0] refresh_seen_reg;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            pre_all_seen_reg <= 1'b0;
            mode_seen_reg <= 1'b0;
            refresh_seen_reg <= '0;
            INIT_DONE <= 1'b0;
        end else begin
            if (cmd_valid && cmd == SBM_CMD_PRECHARGE && ADDR[SBM_PRECHARGE_ALL_BIT]) begin
                pre_all_seen_reg <= 1'b1;
            end
            if (cmd_valid && cmd == SBM_CMD_MODE_SET && all_idle && bank_in == SBM_BA_MODE) begin
                mode_seen_reg <= 1'b1;
            end
            // Refreshes count in either order around the mode set.
            if (cmd_valid && cmd == SBM_CMD_REFRESH &&
                refresh_seen_reg != 2'(SBM_INIT_REFRESHES)) begin
                refresh_seen_reg <= refresh_seen_reg + 2'h1;
            end
            INIT_DONE <= pre_all_seen_reg && mode_seen_reg &&
                         refresh_seen_reg == 2'(SBM_INIT_REFRESHES);
        end
    end

    // ------------------------------------------------------------
    // Burst sequencing and self-refresh
    // ------------------------------------------------------------
    logic [15:0] sr_timer_reg;
    logic [15:0] sr_period;
    logic [1:0] sr_top_bank;

    always_comb begin
        unique case (ext_mode_reg[SBM_EMR_TCSR_LSB +: 2])
            2'h0: sr_period = SBM_SR_PERIOD_0;
            2'h1: sr_period = SBM_SR_PERIOD_1;
            2'h2: sr_period = SBM_SR_PERIOD_2;
            2'h3: sr_period = SBM_SR_PERIOD_3;
        endcase
        unique case (ext_mode_reg[SBM_EMR_PASR_LSB +: 3])
            3'h1: sr_top_bank = 2'h1;
            3'h2: sr_top_bank = 2'h0;
            default: sr_top_bank = 2'h3;
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_reg <= SBM_ST_IDLE;
            bank_reg <= '0;
            col_reg <= '0;
            cnt_reg <= '0;
        end else begin
            unique case (state_reg)
                SBM_ST_IDLE: begin
                    if (!CKE && !CS_N && cmd == SBM_CMD_REFRESH && open_reg == '0) begin
                        state_reg <= SBM_ST_SELF_REFRESH;
                    end
                end
                SBM_ST_SELF_REFRESH: begin
                    if (CKE) begin
                        state_reg <= SBM_ST_IDLE;
                    end
                end
                default: begin
                    cnt_reg <= cnt_reg + 3'h1;
                    if (burst_last) begin
                        state_reg <= SBM_ST_IDLE;
                    end
                end
            endcase
            // A new read or write interrupts any burst in progress.
            if (cmd_valid && (cmd == SBM_CMD_READ || cmd == SBM_CMD_WRITE) &&
                state_reg != SBM_ST_SELF_REFRESH) begin
                // A single-beat access is complete in its command cycle.
                // Entering a burst state here would add a second beat.
                if (len_mask == 3'h0 || (cmd == SBM_CMD_WRITE && mode_reg[SBM_MR_WB_BIT])) begin
                    state_reg <= SBM_ST_IDLE;
                end else begin
                    state_reg <= (cmd == SBM_CMD_READ) ? SBM_ST_READ : SBM_ST_WRITE;
                end
                bank_reg <= bank_in;
                col_reg <= ADDR[SBM_COL_W-1:0];
                cnt_reg <= 3'h1;
            end else if (cmd_valid && (cmd == SBM_CMD_TERMINATE ||
                         cmd == SBM_CMD_PRECHARGE) && state_reg != SBM_ST_SELF_REFRESH) begin
                state_reg <= SBM_ST_IDLE;
            end
        end
    end

    // Only the rows of the selected banks are walked while in self-refresh.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            sr_timer_reg <= '0;
            SELF_REFRESH_ROW <= '0;
            SELF_REFRESH_ACTIVE <= 1'b0;
        end else begin
            SELF_REFRESH_ACTIVE <= (state_reg == SBM_ST_SELF_REFRESH);
            if (state_reg != SBM_ST_SELF_REFRESH) begin
                sr_timer_reg <= '0;
            end else if (sr_timer_reg >= sr_period - 16'h0_001) begin
                sr_timer_reg <= '0;
                if (SELF_REFRESH_ROW[SBM_ROW_W +: 2] >= sr_top_bank &&
                    SELF_REFRESH_ROW[SBM_ROW_W-1:0] == '1) begin
                    SELF_REFRESH_ROW <= '0;
                end else begin
                    SELF_REFRESH_ROW <= SELF_REFRESH_ROW + 15'h0_001;
                end
            end else begin
                sr_timer_reg <= sr_timer_reg + 16'h0_001;
            end
        end
    end

    // ------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------
    logic beat_rd;
    logic beat_wr;
    logic [1:0] beat_bank;
    logic [SBM_COL_W-1:0] beat_col;
    logic [IDX_W-1:0] beat_idx;

    always_comb begin
        beat_rd = 1'b0;
        beat_wr = 1'b0;
        beat_bank = bank_reg;
        beat_col = burst_col(col_reg, cnt_reg, len_mask, mode_reg[SBM_MR_BT_BIT]);
        if (cmd_valid && (cmd == SBM_CMD_READ || cmd == SBM_CMD_WRITE) &&
            state_reg != SBM_ST_SELF_REFRESH) begin
            beat_rd = (cmd == SBM_CMD_READ);
            beat_wr = (cmd == SBM_CMD_WRITE);
            beat_bank = bank_in;
            beat_col = ADDR[SBM_COL_W-1:0];
        end else if (!(cmd_valid && (cmd == SBM_CMD_TERMINATE || cmd == SBM_CMD_PRECHARGE))) begin
            beat_rd = (state_reg == SBM_ST_READ);
            beat_wr = (state_reg == SBM_ST_WRITE);
        end
        beat_idx = store_idx(beat_bank, row_reg[beat_bank], beat_col);
    end

    always_ff @(posedge CLK) begin
        if (beat_wr && !UPPER_BYTE_MASK) begin
            mem_hi_reg[beat_idx] <= DQ_IN[15:8];
        end
        if (beat_wr && !LOWER_BYTE_MASK) begin
            mem_lo_reg[beat_idx] <= DQ_IN[7:0];
        end
    end

    // Read data pipe for CAS latency 2 or 3; masks have their own fixed pipe.
    logic [SBM_DATA_W-1:0] rd_data_reg [2];
    logic [1:0] rd_valid_reg;
    logic [1:0] mask_d1_reg;
    logic out_valid;
    logic [SBM_DATA_W-1:0] out_data;

    assign out_valid = (cl == 3'h3) ? rd_valid_reg[1] : rd_valid_reg[0];
    assign out_data = (cl == 3'h3) ? rd_data_reg[1] : rd_data_reg[0];

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rd_valid_reg <= '0;
            rd_data_reg[0] <= '0;
            rd_data_reg[1] <= '0;
            mask_d1_reg <= 2'h3;
            DQ_OUT <= '0;
            DQ_OE_HIGH <= 1'b0;
            DQ_OE_LOW <= 1'b0;
        end else begin
            rd_valid_reg <= {rd_valid_reg[0], beat_rd};
            rd_data_reg[0] <= {mem_hi_reg[beat_idx], mem_lo_reg[beat_idx]};
            rd_data_reg[1] <= rd_data_reg[0];
            mask_d1_reg <= {UPPER_BYTE_MASK, LOWER_BYTE_MASK};
            DQ_OUT <= out_data;
            DQ_OE_HIGH <= out_valid && !mask_d1_reg[1];
            DQ_OE_LOW <= out_valid && !mask_d1_reg[0];
        end
    end

endmodule

// ### sbm_pkg.sv
package sbm_pkg;

    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int SBM_DATA_W = 16;
    localparam int SBM_ROW_W = 13;
    localparam int SBM_COL_W = 9;
    localparam int SBM_BANK_W = 2;
    localparam int SBM_BANKS = 4;

    // ------------------------------------------------------------
    // Mode register fields and values after reset
    // ------------------------------------------------------------
    localparam int SBM_MR_BL_LSB = 0;
    localparam int SBM_MR_BT_BIT = 3;
    localparam int SBM_MR_CL_LSB = 4;
    localparam int SBM_MR_WB_BIT = 9;
    localparam logic [12:0] SBM_MR_RESET = 13'h0_022;
    localparam int SBM_EMR_PASR_LSB = 0;
    localparam int SBM_EMR_TCSR_LSB = 3;
    localparam logic [4:0] SBM_EMR_RESET = 5'h00;
    localparam logic [1:0] SBM_BA_MODE = 2'h0;
    localparam logic [1:0] SBM_BA_EXT_MODE = 2'h2;
    localparam int SBM_PRECHARGE_ALL_BIT = 10;

    // ------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------
    localparam int SBM_MASK_READ_LATENCY = 2;
    localparam int SBM_INIT_REFRESHES = 2;
    localparam logic [15:0] SBM_SR_PERIOD_0 = 16'h0_7A0;
    localparam logic [15:0] SBM_SR_PERIOD_1 = 16'h0_F40;
    localparam logic [15:0] SBM_SR_PERIOD_2 = 16'h1_E80;
    localparam logic [15:0] SBM_SR_PERIOD_3 = 16'h3_D00;

    // ------------------------------------------------------------
    // Command encoding: {RAS_N, CAS_N, WE_N}
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SBM_CMD_MODE_SET = 3'b000,
        SBM_CMD_REFRESH = 3'b001,
        SBM_CMD_PRECHARGE = 3'b010,
        SBM_CMD_ACTIVATE = 3'b011,
        SBM_CMD_WRITE = 3'b100,
        SBM_CMD_READ = 3'b101,
        SBM_CMD_TERMINATE = 3'b110,
        SBM_CMD_NOP = 3'b111
    } sbm_cmd_e;

    typedef enum logic [1:0] {
        SBM_ST_IDLE = 2'b00,
        SBM_ST_READ = 2'b01,
        SBM_ST_WRITE = 2'b10,
        SBM_ST_SELF_REFRESH = 2'b11
    } sbm_state_e;

endpackage

// ### sbm_core_assertions.sv
module sbm_core_assertions
    import sbm_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CKE,
    input wire logic CS_N,
    input wire logic RAS_N,
    input wire logic CAS_N,
    input wire logic WE_N,
    input wire logic [SBM_ROW_W-1:0] ADDR,
    input wire logic BANK_SELECT_LOW,
    input wire logic BANK_SELECT_HIGH,
    input wire logic UPPER_BYTE_MASK,
    input wire logic LOWER_BYTE_MASK,
    input wire logic DQ_OE_HIGH,
    input wire logic DQ_OE_LOW,
    input wire logic INIT_DONE,
    input wire logic SELF_REFRESH_ACTIVE
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Command tracking.
    // ----------------------------------------
    logic [2:0] cmd;
    logic take;
    logic pre_seen_reg;
    logic mr_seen_reg;
    logic cl3_reg;
    logic [1:0] ref_cnt_reg;
    assign cmd = {RAS_N, CAS_N, WE_N};
    assign take = CKE && !CS_N;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            pre_seen_reg <= 1'h0;
        end else if (take && cmd == SBM_CMD_PRECHARGE && ADDR[SBM_PRECHARGE_ALL_BIT]) begin
            pre_seen_reg <= 1'h1;
        end
    end
    // Mode-set and latency tracking; read checks assume the tests never issue a mode set while a bank is open.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            mr_seen_reg <= 1'h0;
            cl3_reg <= 1'h0;
        end else if (take && cmd == SBM_CMD_MODE_SET
                     && {BANK_SELECT_HIGH, BANK_SELECT_LOW} == SBM_BA_MODE) begin
            mr_seen_reg <= 1'h1;
            cl3_reg <= ADDR[6:4] == 3'h3;
        end
    end
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ref_cnt_reg <= 2'h0;
        end else if (take && cmd == SBM_CMD_REFRESH && ref_cnt_reg != 2'h2) begin
            ref_cnt_reg <= ref_cnt_reg + 2'h1;
        end
    end
    // ----------------------------------------
    // Properties.
    // ----------------------------------------
    default clocking dc @(posedge CLK);
    endclocking
    default disable iff (!RESETN);
    sequence read_taken;
        take && cmd == SBM_CMD_READ && !cl3_reg;
    endsequence
    sequence init_seen;
        pre_seen_reg && mr_seen_reg && ref_cnt_reg == 2'h2;
    endsequence
    sequence sr_entry;
        !CKE && !CS_N && cmd == SBM_CMD_REFRESH;
    endsequence
    upper_read_a: assert property (read_taken ##0 !UPPER_BYTE_MASK |-> ##2 DQ_OE_HIGH)
        else $error("upper lane not driven two cycles after read");
    lower_read_a: assert property (read_taken ##0 !LOWER_BYTE_MASK |-> ##2 DQ_OE_LOW)
        else $error("lower lane not driven two cycles after read");
    upper_float_a: assert property (DQ_OE_HIGH |-> !$past(UPPER_BYTE_MASK, 2))
        else $error("upper lane driven although masked");
    lower_float_a: assert property (DQ_OE_LOW |-> !$past(LOWER_BYTE_MASK, 2))
        else $error("lower lane driven although masked");
    init_order_a: assert property ($rose(INIT_DONE) |-> init_seen)
        else $error("init done before precharge, mode set and two refreshes");
    init_hold_a: assert property (INIT_DONE |=> INIT_DONE)
        else $error("init done dropped");
    sr_enter_a: assert property (sr_entry |-> ##[1:2] SELF_REFRESH_ACTIVE)
        else $error("self refresh not entered");
    sr_quiet_a: assert property (SELF_REFRESH_ACTIVE |-> !DQ_OE_HIGH && !DQ_OE_LOW)
        else $error("data driven in self refresh");
    sr_exit_a: assert property (SELF_REFRESH_ACTIVE && CKE |-> ##[1:2] !SELF_REFRESH_ACTIVE)
        else $error("self refresh not left");
endmodule
bind sbm_sdram_core sbm_core_assertions sbm_core_assertions_i (
    .CLK(CLK), .RESETN(RESETN), .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N),
    .WE_N(WE_N), .ADDR(ADDR), .BANK_SELECT_LOW(BANK_SELECT_LOW),
    .BANK_SELECT_HIGH(BANK_SELECT_HIGH), .UPPER_BYTE_MASK(UPPER_BYTE_MASK),
    .LOWER_BYTE_MASK(LOWER_BYTE_MASK), .DQ_OE_HIGH(DQ_OE_HIGH), .DQ_OE_LOW(DQ_OE_LOW),
    .INIT_DONE(INIT_DONE), .SELF_REFRESH_ACTIVE(SELF_REFRESH_ACTIVE)
);

// ### sbm_ctl_model.sv
module sbm_ctl_model
    import sbm_pkg::*;
#(
    parameter int PAUSE_NS = 200000,
    parameter int CLK_NS = 8,
    parameter int PAUSE_CYCLES = (PAUSE_NS + CLK_NS - 1) / CLK_NS
) (
    input wire logic CLK,
    output logic CKE,
    output logic CS_N,
    output logic RAS_N,
    output logic CAS_N,
    output logic WE_N,
    output logic [SBM_ROW_W-1:0] ADDR,
    output logic BANK_SELECT_LOW,
    output logic BANK_SELECT_HIGH,
    output logic UPPER_BYTE_MASK,
    output logic LOWER_BYTE_MASK,
    output logic [SBM_DATA_W-1:0] DQ
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Idle is NOP with clock enabled and both masks high, so no lane can fight.
    // ----------------------------------------
    initial begin
        CKE = 1'h1;
        CS_N = 1'h0;
        {RAS_N, CAS_N, WE_N} = SBM_CMD_NOP;
        ADDR = 13'h0_000;
        {BANK_SELECT_HIGH, BANK_SELECT_LOW} = 2'h0;
        {UPPER_BYTE_MASK, LOWER_BYTE_MASK} = 2'h3;
        DQ = 16'h0000;
    end
    task automatic issue(input logic cke, input sbm_cmd_e c, input logic [1:0] ba,
                         input logic [12:0] a, input logic [1:0] m, input logic [15:0] d);
        @(posedge CLK);
        CKE <= cke;
        // Deselect and NOP are equivalent, so idle cycles toggle chip select.
        CS_N <= (c == SBM_CMD_NOP) ? ~CS_N : 1'h0;
        {RAS_N, CAS_N, WE_N} <= c;
        {BANK_SELECT_HIGH, BANK_SELECT_LOW} <= ba;
        ADDR <= a;
        {UPPER_BYTE_MASK, LOWER_BYTE_MASK} <= m;
        // Outside a write command cycle the data lines toggle, so stale data never looks valid.
        DQ <= (c == SBM_CMD_WRITE) ? d : ~DQ;
    endtask
    task automatic nop(input int n);
        repeat (n) issue(1'h1, SBM_CMD_NOP, 2'h0, 13'h0_000, 2'h3, 16'h0000);
    endtask
    task automatic power_up(input logic [12:0] mode);
        nop(PAUSE_CYCLES);
        issue(1'h1, SBM_CMD_PRECHARGE, 2'h0, 13'h0_400, 2'h3, 16'h0000);
        nop(2);
        issue(1'h1, SBM_CMD_REFRESH, 2'h0, 13'h0_000, 2'h3, 16'h0000);
        nop(8);
        issue(1'h1, SBM_CMD_MODE_SET, SBM_BA_MODE, mode, 2'h3, 16'h0000);
        nop(2);
        issue(1'h1, SBM_CMD_REFRESH, 2'h0, 13'h0_000, 2'h3, 16'h0000);
        nop(8);
    endtask
endmodule

// ### tb.sv
module tb
    import sbm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK;
    logic RESETN;
    logic CKE, CS_N, RAS_N, CAS_N, WE_N, BSL, BSH, UBM, LBM, DQ_OE_HIGH, DQ_OE_LOW;
    logic INIT_DONE, SELF_REFRESH_ACTIVE;
    logic [12:0] ADDR;
    logic [15:0] DQ, DQ_OUT;
    logic [14:0] SELF_REFRESH_ROW;
    logic [15:0] mem [int];
    int fails;
    int comparisons;
    int seed = 32'h42f3;
    sbm_ctl_model sbm_ctl_model_i (.CLK(CLK), .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N),
        .CAS_N(CAS_N), .WE_N(WE_N), .ADDR(ADDR), .BANK_SELECT_LOW(BSL), .BANK_SELECT_HIGH(BSH),
        .UPPER_BYTE_MASK(UBM), .LOWER_BYTE_MASK(LBM), .DQ(DQ));
    sbm_sdram_core #(.ROW_KEEP(4), .COL_KEEP(4)) sbm_sdram_core_i (.CLK(CLK), .RESETN(RESETN),
        .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N), .ADDR(ADDR),
        .BANK_SELECT_LOW(BSL), .BANK_SELECT_HIGH(BSH), .UPPER_BYTE_MASK(UBM),
        .LOWER_BYTE_MASK(LBM), .DQ_IN(DQ), .DQ_OUT(DQ_OUT), .DQ_OE_HIGH(DQ_OE_HIGH),
        .DQ_OE_LOW(DQ_OE_LOW), .INIT_DONE(INIT_DONE), .SELF_REFRESH_ACTIVE(SELF_REFRESH_ACTIVE),
        .SELF_REFRESH_ROW(SELF_REFRESH_ROW));
    // ----------------------------------------
    // Checking helpers.
    // ----------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Only the low row and column bits are kept, so the model aliases the same way.
    function automatic int key(input logic [1:0] ba, input int r, input int c);
        return {ba, r[3:0], c[3:0]};
    endfunction
    task automatic wr(input logic [1:0] ba, input int r, input int c, input logic [1:0] m,
                      input logic [15:0] d);
        logic [15:0] old;
        old = mem.exists(key(ba, r, c)) ? mem[key(ba, r, c)] : 16'h0000;
        sbm_ctl_model_i.issue(1'h1, SBM_CMD_WRITE, ba, 13'(c), m, d);
        mem[key(ba, r, c)] = {m[1] ? old[15:8] : d[15:8], m[0] ? old[7:0] : d[7:0]};
    endtask
    task automatic rd(input logic [1:0] ba, input int r, input int c, input logic [1:0] m);
        logic [15:0] exp;
        exp = mem[key(ba, r, c)];
        sbm_ctl_model_i.issue(1'h1, SBM_CMD_READ, ba, 13'(c), m, 16'h0000);
        sbm_ctl_model_i.nop(1);
        @(posedge CLK);
        #1;
        check("oe_high", DQ_OE_HIGH, !m[1]);
        check("oe_low", DQ_OE_LOW, !m[0]);
        if (!m[1]) check("data_high", DQ_OUT[15:8], exp[15:8]);
        if (!m[0]) check("data_low", DQ_OUT[7:0], exp[7:0]);
    endtask
    // ----------------------------------------
    // Clock, watchdog and tests.
    // ----------------------------------------
    initial begin
        CLK = 1'h0;
        forever #4 CLK = ~CLK;
    end
    initial begin
        repeat (40000) @(posedge CLK);
        fails++;
        finish_test();
    end
    initial begin
        logic [1:0] m;
        logic [15:0] d;
        fails = 0;
        comparisons = 0;
        RESETN = 1'h0;
        repeat (3) @(posedge CLK);
        RESETN <= 1'h1;
        sbm_ctl_model_i.power_up(13'h0_220);
        #1;
        check("init_done", INIT_DONE, 1'h1);
        for (int b = 0; b < 4; b++) begin
            sbm_ctl_model_i.issue(1'h1, SBM_CMD_ACTIVATE, 2'(b), 13'(b + 5), 2'h3, 16'h0000);
            sbm_ctl_model_i.nop(3);
            for (int c = 0; c < 4; c++) wr(2'(b), b + 5, c, 2'h0, 16'($random(seed)));
        end
        // Back-to-back masked writes across all open banks.
        for (int i = 0; i < 24; i++) begin
            m = 2'($random(seed));
            d = 16'($random(seed));
            wr(2'(i % 4), i % 4 + 5, (i / 4) % 4, m, d);
        end
        sbm_ctl_model_i.nop(2);
        for (int i = 0; i < 16; i++) rd(2'(i % 4), i % 4 + 5, i / 4, 2'($random(seed)));
        sbm_ctl_model_i.issue(1'h1, SBM_CMD_PRECHARGE, 2'h0, 13'h0_400, 2'h3, 16'h0000);
        sbm_ctl_model_i.nop(3);
        sbm_ctl_model_i.issue(1'h0, SBM_CMD_REFRESH, 2'h0, 13'h0_000, 2'h3, 16'h0000);
        repeat (20) sbm_ctl_model_i.issue(1'h0, SBM_CMD_NOP, 2'h0, 13'h0_000, 2'h3, 16'h0000);
        #1;
        check("sr_active", SELF_REFRESH_ACTIVE, 1'h1);
        sbm_ctl_model_i.nop(5);
        #1;
        check("sr_left", SELF_REFRESH_ACTIVE, 1'h0);
        sbm_ctl_model_i.issue(1'h1, SBM_CMD_ACTIVATE, 2'h2, 13'h0_007, 2'h3, 16'h0000);
        sbm_ctl_model_i.nop(3);
        rd(2'h2, 7, 3, 2'h0);
        finish_test();
    end
endmodule
